/* File: oecr_regs.sv */
// OTG event enables, status, latch, debug, scratch and accessory switch control
//
// Behaviour
// - Read at base; write, set, clear offsets.
// - Rising enables, five bits, default ones.
// - Falling enables, same order, default ones.
// - Downstream detach events only in host mode.
// - Status returns live comparator values, upper zero.
// - After reset status follows comparators.
// - Enabled edges set latch bits.
// - Latch read returns events, then clears.
// - Debug returns line state, upper zero.
// - Scratch resets zero, no side effects.
// - Data line 1 high without receive route.
// - Bits 2 and 3 route UART lines.
// - Bit 1 pulls ID low; bits 0,7 zero.
// - Bit 4 joins minus line to left.
// - Bit 5 or 6 joins plus line.
// - UART mode shows UART on switched pins.
// - Audio switch disables single-ended receivers.
// - Accessory mode bit owned by interface control.
`timescale 1ns/1ps
`include "oecr_consts.svh"

module oecr_regs (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire oecr_pkg::oecr_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   input wire oecr_pkg::oecr_comp_t comp_i,
   input wire logic host_mode_i,
   input wire logic [1:0] line_state_i,
   input wire logic accessory_mode_i,
   input wire logic dp_rx_level_i,
   output logic ulpi_data1_o,
   output oecr_pkg::oecr_sw_t sw_o
);
   import oecr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Write/set/clear registers

   localparam logic [3:0][5:0] WSC_BASE = {`OECR_ACC_BASE, `OECR_SCRATCH_BASE,
                                           `OECR_FALL_BASE, `OECR_RISE_BASE};
   localparam logic [3:0][7:0] WSC_MASK = {`OECR_ACC_MASK, `OECR_SCRATCH_MASK,
                                           `OECR_EDGE_MASK, `OECR_EDGE_MASK};
   localparam logic [3:0][7:0] WSC_RST = {`OECR_ACC_RESET, `OECR_SCRATCH_RESET,
                                          `OECR_EDGE_RESET, `OECR_EDGE_RESET};

   logic [3:0][7:0] wsc_val;

   genvar gi;
   generate
      for (gi = 0; gi < `OECR_NUM_WSC; gi = gi + 1) begin : g_wsc
         oecr_wsc_reg #(
            .BASE(WSC_BASE[gi]),
            .MASK(WSC_MASK[gi]),
            .RESET_VAL(WSC_RST[gi])
         ) u_reg (
            .ref_clk_i(ref_clk_i),
            .srst_i(srst_i),
            .req_i(req_i),
            .val_o(wsc_val[gi])
         );
      end
   endgenerate

   logic [4:0] rise_en;
   logic [4:0] fall_en;
   logic [7:0] scratch;
   logic [7:0] acc;

   assign rise_en = wsc_val[0][4:0];
   assign fall_en = wsc_val[1][4:0];
   // Scratch is only read back; nothing else looks at it
   assign scratch = wsc_val[2];
   assign acc = wsc_val[3];

   ////////////////////////////////////////////////////////////////////////////////
   // State

   oecr_state_t st_ff;
   oecr_state_t nxt_st;

   logic [4:0] comp_vec;
   logic [4:0] rise_evt;
   logic [4:0] fall_evt;
   logic [4:0] evt;
   logic [4:0] evt_gate;
   logic latch_rd;
   logic audio_on;

   assign comp_vec = comp_i;
   // Detach has no meaning outside host mode, so its edges are dropped there
   assign evt_gate = {4'hf, host_mode_i};
   assign rise_evt = comp_vec & ~st_ff.prev & rise_en;
   assign fall_evt = ~comp_vec & st_ff.prev & fall_en;
   assign evt = (rise_evt | fall_evt) & evt_gate;
   assign latch_rd = req_i.rd && req_i.addr == `OECR_LATCH_ADDR;
   assign audio_on = acc[`OECR_ACC_LEFT] | acc[`OECR_ACC_RIGHT] | acc[`OECR_ACC_MIC];

   // Read decode of a write/set/clear triple
   function automatic logic in_triple(input logic [5:0] a, input logic [5:0] base);
      in_triple = (a >= base) && (a <= base + `OECR_OFS_CLEAR);
   endfunction

   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev = comp_vec;
      // Set wins over the read clear so a coincident edge is kept
      nxt_st.latch = (latch_rd ? 5'h00 : st_ff.latch) | evt;
      nxt_st.rvalid = req_i.rd;
      if (req_i.rd) begin
         if (in_triple(req_i.addr, `OECR_RISE_BASE)) begin
            nxt_st.rdata = wsc_val[0];
         end else if (in_triple(req_i.addr, `OECR_FALL_BASE)) begin
            nxt_st.rdata = wsc_val[1];
         end else if (req_i.addr == `OECR_STATUS_ADDR) begin
            nxt_st.rdata = {3'h0, comp_vec};
         end else if (req_i.addr == `OECR_LATCH_ADDR) begin
            nxt_st.rdata = {3'h0, st_ff.latch};
         end else if (req_i.addr == `OECR_DEBUG_ADDR) begin
            nxt_st.rdata = {6'h00, line_state_i};
         end else if (in_triple(req_i.addr, `OECR_SCRATCH_BASE)) begin
            nxt_st.rdata = scratch;
         end else if (in_triple(req_i.addr, `OECR_ACC_BASE)) begin
            nxt_st.rdata = acc;
         end else begin
            nxt_st.rdata = 8'h00;
         end
      end
      // Link programs routing before selecting accessory mode, so no glitch on entry
      nxt_st.sw.id_pull_low_drive = acc[`OECR_ACC_ID_PULL];
      nxt_st.sw.uart_tx_to_dm = acc[`OECR_ACC_TX_ROUTE];
      nxt_st.sw.dp_to_uart_rx = acc[`OECR_ACC_RX_ROUTE];
      nxt_st.sw.left_audio_switch = acc[`OECR_ACC_LEFT];
      nxt_st.sw.right_mic_switch = acc[`OECR_ACC_RIGHT] | acc[`OECR_ACC_MIC];
      nxt_st.sw.se_rx_disable = audio_on;
      // Mode bit itself lives in the interface control register
      nxt_st.sw.uart_on_left_audio_pin = accessory_mode_i & acc[`OECR_ACC_LEFT];
      nxt_st.sw.uart_on_right_mic_audio_pin = accessory_mode_i
                                              & (acc[`OECR_ACC_RIGHT] | acc[`OECR_ACC_MIC]);
      // Idle level of UART receive is high; mirrors the plus line when routed
      nxt_st.ulpi_data1 = acc[`OECR_ACC_RX_ROUTE] ? dp_rx_level_i : 1'b1;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         // Edge memory seeded from the comparators so reset makes no false event
         st_ff.prev <= comp_vec;
         st_ff.latch <= 5'h00;
         st_ff.rdata <= 8'h00;
         st_ff.rvalid <= 1'b0;
         st_ff.ulpi_data1 <= 1'b1;
         st_ff.sw <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_o = st_ff.rdata;
   assign rvalid_o = st_ff.rvalid;
   assign ulpi_data1_o = st_ff.ulpi_data1;
   assign sw_o = st_ff.sw;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   sequence latch_rd_s;
      req_i.rd && req_i.addr == 6'h14;
   endsequence

   sequence quiet_s;
      evt == 5'h00;
   endsequence

   status_live_a: assert property (req_i.rd && req_i.addr == 6'h13 |=> rdata_o == {3'h0, $past(comp_vec)})
      else $error("status read not the live comparators");
   debug_read_a: assert property (req_i.rd && req_i.addr == 6'h15 |=> rdata_o == {6'h00, $past(line_state_i)})
      else $error("debug read not the line state");
   latch_return_a: assert property (latch_rd_s |=> rdata_o == {3'h0, $past(st_ff.latch)} && rvalid_o)
      else $error("latch read returned wrong bits");
   latch_clear_a: assert property (latch_rd_s ##0 quiet_s |=> st_ff.latch == 5'h00)
      else $error("latch not cleared by read");
   latch_keep_a: assert property (latch_rd_s ##0 (evt != 5'h00) |=> st_ff.latch == $past(evt))
      else $error("event lost during latch read");
   rise_set_a: assert property (rise_en[1] && !st_ff.prev[1] && comp_vec[1] |=> st_ff.latch[1])
      else $error("enabled rising edge not latched");
   masked_edge_a: assert property (!latch_rd && fall_en[2] == 1'b0 && rise_en[2] == 1'b0 && !st_ff.latch[2]
                                   |=> !st_ff.latch[2])
      else $error("masked edge set a latch bit");
   detach_gate_a: assert property (!host_mode_i && !st_ff.latch[0] |=> !st_ff.latch[0])
      else $error("detach event outside host mode");
   data1_high_a: assert property (!acc[3] |=> ulpi_data1_o)
      else $error("data line 1 not held high");
   right_join_a: assert property (acc[5] || acc[6] |=> sw_o.right_mic_switch)
      else $error("plus line not joined to right audio pin");
   se_off_a: assert property ((acc[6:4] != 3'h0) |=> sw_o.se_rx_disable && sw_o.se_rx_disable == (|$past(acc[6:4])))
      else $error("single-ended receivers not disabled");
   acc_fixed_a: assert property (acc[0] == 1'b0 && acc[7] == 1'b0)
      else $error("accessory reserved bit set");
   reset_quiet_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
                                   srst_i ##1 (!srst_i && comp_vec == $past(comp_vec)) |=> st_ff.latch == 5'h00)
      else $error("reset left a false event");
endmodule

/* File: oecr_consts.svh */
// Offsets, field positions, reset values and masks of the OTG event and accessory registers
`ifndef OECR_CONSTS_SVH
`define OECR_CONSTS_SVH

`define OECR_ADDR_W 6
`define OECR_RISE_BASE 6'h0d
`define OECR_FALL_BASE 6'h10
`define OECR_STATUS_ADDR 6'h13
`define OECR_LATCH_ADDR 6'h14
`define OECR_DEBUG_ADDR 6'h15
`define OECR_SCRATCH_BASE 6'h16
`define OECR_ACC_BASE 6'h19

// Offsets within a write/set/clear triple
`define OECR_OFS_WRITE 6'h00
`define OECR_OFS_SET 6'h01
`define OECR_OFS_CLEAR 6'h02

// Writable bit masks
`define OECR_EDGE_MASK 8'h1f
`define OECR_SCRATCH_MASK 8'hff
`define OECR_ACC_MASK 8'h7e

// Reset values
`define OECR_EDGE_RESET 8'h1f
`define OECR_SCRATCH_RESET 8'h00
`define OECR_ACC_RESET 8'h00

// Event bit positions
`define OECR_BIT_HOST_DISC 0
`define OECR_NUM_EVENTS 5

// Accessory control fields
`define OECR_ACC_ID_PULL 1
`define OECR_ACC_TX_ROUTE 2
`define OECR_ACC_RX_ROUTE 3
`define OECR_ACC_LEFT 4
`define OECR_ACC_RIGHT 5
`define OECR_ACC_MIC 6

`define OECR_NUM_WSC 4

`endif

/* File: oecr_pkg.sv */
// Types shared by the OTG event and accessory register bank
package oecr_pkg;

   // One register access from the ULPI register-access engine
   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } oecr_req_t;

   // Comparator and detector outputs, in register bit order 4..0
   typedef struct packed {
      logic id_grounded;
      logic session_over;
      logic session_ok;
      logic bus_power_ok;
      logic downstream_detach;
   } oecr_comp_t;

   // Switch and routing controls toward the analog front end
   typedef struct packed {
      logic id_pull_low_drive;
      logic uart_tx_to_dm;
      logic dp_to_uart_rx;
      logic left_audio_switch;
      logic right_mic_switch;
      logic se_rx_disable;
      logic uart_on_left_audio_pin;
      logic uart_on_right_mic_audio_pin;
   } oecr_sw_t;

   typedef struct packed {
      logic [7:0] val;
   } oecr_wsc_state_t;

   typedef struct packed {
      logic [4:0] prev;
      logic [4:0] latch;
      logic [7:0] rdata;
      logic rvalid;
      logic ulpi_data1;
      oecr_sw_t sw;
   } oecr_state_t;

endpackage

/* File: oecr_wsc_reg.sv */
// One byte register with write, set and clear offsets
`timescale 1ns/1ps
`include "oecr_consts.svh"

module oecr_wsc_reg #(
   parameter logic [5:0] BASE = 6'h00,
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire oecr_pkg::oecr_req_t req_i,
   output logic [7:0] val_o
);
   import oecr_pkg::*;

   oecr_wsc_state_t st_ff;
   oecr_wsc_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (req_i.wr) begin
         // Reserved bits never take a one
         if (req_i.addr == BASE + `OECR_OFS_WRITE) begin
            nxt_st.val = req_i.wdata & MASK;
         end else if (req_i.addr == BASE + `OECR_OFS_SET) begin
            nxt_st.val = (st_ff.val | req_i.wdata) & MASK;
         end else if (req_i.addr == BASE + `OECR_OFS_CLEAR) begin
            nxt_st.val = st_ff.val & ~req_i.wdata & MASK;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_ff.val <= RESET_VAL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign val_o = st_ff.val;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   wr_replace_a: assert property (req_i.wr && req_i.addr == BASE |=> val_o == ($past(req_i.wdata) & MASK))
      else $error("write offset did not replace contents");
   set_or_a: assert property (req_i.wr && req_i.addr == BASE + 6'h01 |=> val_o == (($past(val_o) | $past(req_i.wdata)) & MASK))
      else $error("set offset did not OR in bits");
   clr_and_a: assert property (req_i.wr && req_i.addr == BASE + 6'h02 |=> val_o == ($past(val_o) & ~$past(req_i.wdata)))
      else $error("clear offset did not clear bits");
   reserved_zero_a: assert property ((val_o & ~MASK) == 8'h00)
      else $error("reserved bit read as one");
   reset_val_a: assert property (@(posedge ref_clk_i) disable iff (1'b0) srst_i |=> val_o == RESET_VAL)
      else $error("register missed its reset value");
endmodule

/* File: oecr_link_model.sv */
// Link-side model: issues register accesses and owns the accessory mode bit
`timescale 1ns/1ps

module oecr_link_model (
   input wire logic ref_clk_i,
   output oecr_pkg::oecr_req_t req_o,
   output logic accessory_mode_o
);
   import oecr_pkg::*;

   initial begin
      req_o = '0;
      accessory_mode_o = 1'b0;
   end

   // Caller sits just past an edge; the request is taken at the next one
   task automatic access(input logic rd, input logic wr, input logic [5:0] a,
                         input logic [7:0] d);
      req_o <= '{rd: rd, wr: wr, addr: a, wdata: d};
      @(posedge ref_clk_i);
   endtask

   task automatic idle();
      req_o <= '0;
      @(posedge ref_clk_i);
   endtask

   // Routes go in before the mode bit moves; audio use never carries UART routes
   task automatic set_acc(input logic [7:0] v, input logic mode, output logic [7:0] sent);
      sent = (|v[6:4]) ? (v & 8'hf3) : v;
      access(1'b0, 1'b1, 6'h19, sent);
      idle();
      accessory_mode_o <= mode;
      @(posedge ref_clk_i);
   endtask
endmodule

/* File: oecr_regs_tb.sv */
// Self-checking bench for the OTG event and accessory register bank
`timescale 1ns/1ps

module oecr_regs_tb;
   import oecr_pkg::*;

   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   oecr_req_t req;
   logic [7:0] rdata;
   logic rvalid, acc_mode, host_mode, dp_rx, ulpi_d1;
   logic [1:0] line_state;
   oecr_comp_t comp;
   oecr_sw_t sw, e_sw;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   int bad_count = 0;
   int num_checks = 0;
   logic [5:0] ra[9] = '{6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h12, 6'h14, 6'h16, 6'h19, 6'h3f};
   logic [7:0] rv[9] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [5:0] wb[4] = '{6'h0d, 6'h10, 6'h16, 6'h19};
   logic [7:0] wm[4] = '{8'h1f, 8'h1f, 8'hff, 8'h7e};

   always #12.5 ref_clk_i = ~ref_clk_i;

   oecr_link_model link_u (.ref_clk_i(ref_clk_i), .req_o(req), .accessory_mode_o(acc_mode));

   oecr_regs dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata),
      .rvalid_o(rvalid), .comp_i(comp), .host_mode_i(host_mode), .line_state_i(line_state),
      .accessory_mode_i(acc_mode), .dp_rx_level_i(dp_rx), .ulpi_data1_o(ulpi_d1), .sw_o(sw));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // A zero mask marks a read made only to empty the latch
   task automatic rd(input logic [5:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
      exp_q.push_back({m, exp});
      link_u.access(1'b1, 1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      link_u.access(1'b0, 1'b1, a, d);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Read data is registered on the taking edge itself; sampled once it has settled
   always @(posedge ref_clk_i) begin
      #1;
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("MISMATCH read valid expected none seen %h", rdata);
         end else begin
            e = exp_q.pop_front();
            check("read data", e[7:0] & e[15:8], rdata & e[15:8]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] a, b, c, sent;
      a = $urandom(65123);
      comp = 5'($urandom);
      host_mode = 1'b1;
      line_state = 2'h0;
      dp_rx = 1'b0;
      repeat (8) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd(6'h13, {3'h0, comp});
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 4; i++) begin
         a = $urandom;
         b = $urandom;
         c = $urandom;
         wr(wb[i], a);
         wr(wb[i] + 6'h01, b);
         wr(wb[i] + 6'h02, c);
         rd(wb[i] + 6'h01, ((a | b) & ~c) & wm[i]);
      end
      wr(6'h14, 8'hff);
      rd(6'h14, 8'h00);
      wr(6'h0d, 8'h1f);
      wr(6'h10, 8'h1f);
      for (int i = 0; i < 6; i++) begin
         comp <= 5'($urandom);
         line_state <= 2'($urandom);
         link_u.idle();
         rd(6'h13, {3'h0, comp});
         rd(6'h15, {6'h00, line_state});
      end
      comp <= '0;
      link_u.idle();
      link_u.idle();
      rd(6'h14, 8'h00, 8'h00);
      // Each bit rises then falls; the detach bit rises outside host mode
      for (int i = 0; i < 5; i++) begin
         for (int h = 0; h < 2; h++) begin
            host_mode <= h[0];
            comp[i] <= ~comp[i];
            link_u.idle();
            link_u.idle();
            rd(6'h14, (i == 0 && h == 0) ? 8'h00 : 8'(8'h01 << i));
         end
      end
      wr(6'h0f, 8'h1f);
      comp <= 5'h1f;
      link_u.idle();
      link_u.idle();
      rd(6'h14, 8'h00);
      comp <= '0;
      rd(6'h14, 8'h00);
      link_u.idle();
      rd(6'h14, 8'h1f);
      for (int i = 0; i < 16; i++) begin
         a = $urandom;
         if (i[0]) a[6:4] = 3'h0;
         dp_rx <= 1'($urandom);
         link_u.set_acc(a, 1'($urandom), sent);
         link_u.idle();
         #1;
         e_sw = '{id_pull_low_drive: sent[1], uart_tx_to_dm: sent[2], dp_to_uart_rx: sent[3],
            left_audio_switch: sent[4], right_mic_switch: sent[5] | sent[6],
            se_rx_disable: |sent[6:4], uart_on_left_audio_pin: acc_mode & sent[4],
            uart_on_right_mic_audio_pin: acc_mode & (sent[5] | sent[6])};
         check("switches", 8'(e_sw), 8'(sw));
         check("data line 1", {7'h0, sent[3] ? dp_rx : 1'b1}, {7'h0, ulpi_d1});
         rd(6'h1b, sent & 8'h7e);
      end
      link_u.idle();
      for (int k = 0; k < 10 && exp_q.size() != 0; k++) @(posedge ref_clk_i);
      if (exp_q.size() != 0) begin
         bad_count++;
         $display("MISMATCH pending reads expected 0 seen %0d", exp_q.size());
      end
      results();
   end

   // A hang is cut short here
   initial begin
      #1000000;
      bad_count++;
      $display("MISMATCH run length expected done seen timeout");
      results();
   end
endmodule
